// *** oscsel_pkg.sv ***
// Constants and types of the oscillator clock source selection block
package oscsel_pkg;
  localparam logic [1:0] SRC_INTERNAL = 2'b00;
  localparam logic [1:0] SRC_EXT_CLK  = 2'b01;
  localparam logic [1:0] SRC_RC       = 2'b10;
  localparam logic [1:0] SRC_CRYSTAL  = 2'b11;
  localparam logic [1:0] FREQ_4M0     = 2'b00;
  localparam logic [1:0] FREQ_8M0     = 2'b01;
  localparam logic [1:0] FREQ_12M8    = 2'b10;
  localparam logic [1:0] FREQ_25M6    = 2'b11;
  localparam logic [1:0] XRANGE_HIGH  = 2'b00;
  localparam logic [1:0] XRANGE_MID   = 2'b01;
  localparam logic [1:0] XRANGE_LOW   = 2'b10;
  localparam logic [1:0] XRANGE_RSVD  = 2'b11;
  localparam int         SYS_CLK_MHZ  = 250;
  // Half periods in system clock cycles for each internal setting, untrimmed
  localparam logic [7:0] HALF_4M0     = 8'h1F;
  localparam logic [7:0] HALF_8M0     = 8'h0F;
  localparam logic [7:0] HALF_12M8    = 8'h0A;
  localparam logic [7:0] HALF_25M6    = 8'h05;
  localparam int         TRIM_FRAC    = 9;
  localparam int         EDGES_NEEDED = 2;
  localparam logic [7:0] TRIM_RESET   = 8'h80;
  typedef enum logic [2:0] {
    OSCSEL_INT, OSCSEL_WAIT_EDGES, OSCSEL_ENGAGE, OSCSEL_EXT, OSCSEL_RESTART
  } oscsel_state_t;
endpackage

// *** oscsel_clk_if.sv ***
// Interface carrying a selected source clock level and its edge marks
`timescale 1ns/1ps
`default_nettype none
interface oscsel_clk_if;
  logic level;
  logic rise;
  logic run;
  modport src (output level, output rise, input run);
  modport snk (input level, input rise, output run);
endinterface
`default_nettype wire

// *** oscsel_int_osc.sv ***
// Model of the trimmable internal oscillator as a divided system clock
`timescale 1ns/1ps
`default_nettype none
module oscsel_int_osc
  import oscsel_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // Control
  input  wire logic [1:0] freq_sel_i,
  input  wire logic [7:0] trim_i,
  // Clock out
  oscsel_clk_if.src       clk_o
);
  logic [7:0]  half_base;
  logic [15:0] half_trim;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        lvl_reg;
  logic        lvl_next;
  logic        rise_reg;
  logic        rise_next;
  logic signed [8:0] trim_s;

  always_comb begin
    unique case (freq_sel_i)
      FREQ_4M0:  half_base = HALF_4M0;
      FREQ_8M0:  half_base = HALF_8M0;
      FREQ_12M8: half_base = HALF_12M8;
      FREQ_25M6: half_base = HALF_25M6;
    endcase
    // Signed trim, larger value lengthens period
    trim_s    = $signed({trim_i[7], trim_i});
    half_trim = 16'((($signed({8'h00, half_base}) <<< TRIM_FRAC)
                + $signed(16'(trim_s)) * $signed({8'h00, half_base}))
                >>> TRIM_FRAC);
    if (half_trim == 16'h0000) half_trim = 16'h0001;
    cnt_next  = cnt_reg;
    lvl_next  = lvl_reg;
    rise_next = 1'b0;
    if (!clk_o.run) begin
      cnt_next = 16'h0000;
      lvl_next = 1'b0;
    end else if (cnt_reg + 16'h0001 >= half_trim) begin
      cnt_next  = 16'h0000;
      lvl_next  = !lvl_reg;
      rise_next = !lvl_reg;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg  <= 16'h0000;
      lvl_reg  <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      lvl_reg  <= lvl_next;
      rise_reg <= rise_next;
    end
  end

  assign clk_o.level = lvl_reg;
  assign clk_o.rise  = rise_reg;
endmodule
`default_nettype wire

// *** oscsel_ext_sync.sv ***
// Synchroniser and rising edge finder for the external source clock
`timescale 1ns/1ps
`default_nettype none
module oscsel_ext_sync
  import oscsel_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // Raw source
  input  wire logic raw_i,
  // Synchronised clock
  oscsel_clk_if.src clk_o
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       rise_reg;
  logic       rise_next;

  always_comb begin
    sh_next   = {sh_reg[1:0], raw_i};
    rise_next = sh_reg[1] && !sh_reg[2];
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_reg   <= 3'b000;
      rise_reg <= 1'b0;
    end else begin
      sh_reg   <= sh_next;
      rise_reg <= rise_next;
    end
  end

  assign clk_o.level = sh_reg[2];
  assign clk_o.rise  = rise_reg;
endmodule
`default_nettype wire

// *** oscsel_top.sv ***
// Clock source selection, switchover and pin sharing of the oscillator
`timescale 1ns/1ps
`default_nettype none
module oscsel_top
  import oscsel_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // Configuration
  input  wire logic [1:0] source_option_field_i,
  input  wire logic [1:0] internal_freq_field_i,
  input  wire logic [1:0] crystal_range_field_i,
  input  wire logic       external_clock_enable_i,
  input  wire logic       clock_out_pin_enable_i,
  input  wire logic [7:0] internal_trim_value_i,
  input  wire logic       osc_on_in_stop_i,
  // Power mode
  input  wire logic       stop_osc_enable_signal_i,
  input  wire logic       wait_mode_i,
  // Oscillator pins and analog sources
  input  wire logic       osc_in_pin_i,
  input  wire logic       crystal_osc_clock_i,
  input  wire logic       rc_osc_clock_i,
  output logic            osc_in_pin_owned_o,
  output logic            osc_out_pin_o,
  output logic            osc_out_pin_oe_n_o,
  output logic            osc_out_pin_owned_o,
  output logic            crystal_amp_en_o,
  output logic [2:0]      crystal_amp_sel_o,
  output logic            rc_osc_en_o,
  // Clocks and status
  output logic            full_rate_clock_o,
  output logic            half_rate_clock_o,
  output logic            internal_osc_run_o,
  output logic            external_clock_engaged_o,
  output logic            effective_clock_out_enable_o
);
  oscsel_clk_if int_clk ();
  oscsel_clk_if ext_clk ();

  oscsel_state_t st_reg;
  oscsel_state_t st_next;
  logic [1:0]    edge_reg;
  logic [1:0]    edge_next;
  logic          engaged_reg;
  logic          engaged_next;
  logic          use_ext_reg;
  logic          use_ext_next;
  logic          int_run_reg;
  logic          int_run_next;
  logic          full_reg;
  logic          full_next;
  logic          half_reg;
  logic          half_next;
  logic          in_own_reg;
  logic          in_own_next;
  logic          out_reg;
  logic          out_next;
  logic          oe_n_reg;
  logic          oe_n_next;
  logic          out_own_reg;
  logic          out_own_next;
  logic          xamp_en_reg;
  logic          xamp_en_next;
  logic [2:0]    xamp_sel_reg;
  logic [2:0]    xamp_sel_next;
  logic          rc_en_reg;
  logic          rc_en_next;
  logic          eff_oe_reg;
  logic          eff_oe_next;
  logic          osc_allowed;
  logic          ext_src_raw;
  logic          sel_level;
  logic          sel_rise;
  logic [2:0]    src_meta_reg;
  logic [2:0]    src_meta_next;
  logic [2:0]    src_sync_reg;
  logic [2:0]    src_sync_next;

  // Trim is a port straight into the oscillator; nothing preloads it
  oscsel_int_osc u_int_osc (
    .clk_sys_i  (clk_sys_i),
    .arst_n_i   (arst_n_i),
    .freq_sel_i (internal_freq_field_i),
    .trim_i     (internal_trim_value_i),
    .clk_o      (int_clk.src)
  );

  oscsel_ext_sync u_ext_sync (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .raw_i     (ext_src_raw),
    .clk_o     (ext_clk.src)
  );

  // Two-flop capture of the three asynchronous source inputs
  always_comb begin
    src_meta_next = {crystal_osc_clock_i, rc_osc_clock_i, osc_in_pin_i};
    src_sync_next = src_meta_reg;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_meta_reg <= 3'b000;
      src_sync_reg <= 3'b000;
    end else begin
      src_meta_reg <= src_meta_next;
      src_sync_reg <= src_sync_next;
    end
  end

  // Captured external source per option
  always_comb begin
    unique case (source_option_field_i)
      SRC_RC:      ext_src_raw = src_sync_reg[1];
      SRC_CRYSTAL: ext_src_raw = src_sync_reg[2];
      default:     ext_src_raw = src_sync_reg[0];
    endcase
  end

  // Stop gating; wait mode has no effect on any clock
  assign osc_allowed  = stop_osc_enable_signal_i || osc_on_in_stop_i;
  assign int_clk.run  = int_run_reg && osc_allowed;
  assign ext_clk.run  = 1'b1;

  // Switchover state machine
  always_comb begin
    st_next      = st_reg;
    edge_next    = edge_reg;
    engaged_next = engaged_reg;
    use_ext_next = use_ext_reg;
    int_run_next = int_run_reg;
    unique case (st_reg)
      OSCSEL_INT: begin
        edge_next = 2'b00;
        if (external_clock_enable_i && source_option_field_i != SRC_INTERNAL) begin
          st_next = OSCSEL_WAIT_EDGES;
        end
      end
      OSCSEL_WAIT_EDGES: begin
        if (!external_clock_enable_i) begin
          st_next = OSCSEL_INT;
        end else if (ext_clk.rise) begin
          if (edge_reg == 2'(EDGES_NEEDED - 1)) begin
            st_next = OSCSEL_ENGAGE;
          end else begin
            edge_next = edge_reg + 2'b01;
          end
        end
      end
      OSCSEL_ENGAGE: begin
        // Mux swaps to the external clock only while both clocks are low
        if (!external_clock_enable_i) begin
          st_next = OSCSEL_INT;
        end else if (!int_clk.level && !ext_clk.level) begin
          use_ext_next = 1'b1;
          engaged_next = 1'b1;
          st_next      = OSCSEL_EXT;
        end
      end
      OSCSEL_EXT: begin
        int_run_next = 1'b0;
        if (!external_clock_enable_i && source_option_field_i == SRC_INTERNAL) begin
          int_run_next = 1'b1;
          st_next      = OSCSEL_RESTART;
        end
      end
      OSCSEL_RESTART: begin
        if (int_clk.rise) begin
          use_ext_next = 1'b0;
          engaged_next = 1'b0;
          st_next      = OSCSEL_INT;
        end
      end
    endcase
  end

  // Clock outputs and pin control
  always_comb begin
    sel_level = use_ext_reg ? ext_clk.level : int_clk.level;
    sel_rise  = use_ext_reg ? ext_clk.rise : int_clk.rise;
    full_next = sel_level;
    half_next = half_reg;
    if (sel_rise) begin
      half_next = !half_reg;
    end
    // Bus clock divider by two sits downstream of the half-rate clock
    if (wait_mode_i) begin
      full_next = sel_level;
    end
    // First pin owned whenever an external option is written
    in_own_next  = source_option_field_i != SRC_INTERNAL;
    out_own_next = 1'b0;
    eff_oe_next  = 1'b0;
    xamp_en_next = 1'b0;
    rc_en_next   = 1'b0;
    unique case (source_option_field_i)
      SRC_INTERNAL: begin
        in_own_next = 1'b0;
        eff_oe_next = clock_out_pin_enable_i;
      end
      SRC_EXT_CLK: begin
        eff_oe_next = 1'b0;
      end
      SRC_RC: begin
        rc_en_next  = osc_allowed;
        eff_oe_next = clock_out_pin_enable_i;
      end
      SRC_CRYSTAL: begin
        out_own_next = 1'b1;
        xamp_en_next = osc_allowed && crystal_range_field_i != XRANGE_RSVD;
      end
    endcase
    unique case (crystal_range_field_i)
      XRANGE_HIGH: xamp_sel_next = 3'b001;
      XRANGE_MID:  xamp_sel_next = 3'b010;
      XRANGE_LOW:  xamp_sel_next = 3'b100;
      XRANGE_RSVD: xamp_sel_next = 3'b000;
    endcase
    if (source_option_field_i != SRC_CRYSTAL) begin
      xamp_sel_next = 3'b000;
    end
    out_own_next = out_own_next || eff_oe_next;
    oe_n_next    = !eff_oe_next;
    out_next     = eff_oe_next && sel_level;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg       <= OSCSEL_INT;
      edge_reg     <= 2'b00;
      engaged_reg  <= 1'b0;
      use_ext_reg  <= 1'b0;
      int_run_reg  <= 1'b1;
      full_reg     <= 1'b0;
      half_reg     <= 1'b0;
      in_own_reg   <= 1'b0;
      out_reg      <= 1'b0;
      oe_n_reg     <= 1'b1;
      out_own_reg  <= 1'b0;
      xamp_en_reg  <= 1'b0;
      xamp_sel_reg <= 3'b000;
      rc_en_reg    <= 1'b0;
      eff_oe_reg   <= 1'b0;
    end else begin
      st_reg       <= st_next;
      edge_reg     <= edge_next;
      engaged_reg  <= engaged_next;
      use_ext_reg  <= use_ext_next;
      int_run_reg  <= int_run_next;
      full_reg     <= full_next;
      half_reg     <= half_next;
      in_own_reg   <= in_own_next;
      out_reg      <= out_next;
      oe_n_reg     <= oe_n_next;
      out_own_reg  <= out_own_next;
      xamp_en_reg  <= xamp_en_next;
      xamp_sel_reg <= xamp_sel_next;
      rc_en_reg    <= rc_en_next;
      eff_oe_reg   <= eff_oe_next;
    end
  end

  // No interrupt or flag outputs exist in this block
  assign full_rate_clock_o            = full_reg;
  assign half_rate_clock_o            = half_reg;
  assign internal_osc_run_o           = int_run_reg;
  assign external_clock_engaged_o     = engaged_reg;
  assign osc_in_pin_owned_o           = in_own_reg;
  assign osc_out_pin_o                = out_reg;
  assign osc_out_pin_oe_n_o           = oe_n_reg;
  assign osc_out_pin_owned_o          = out_own_reg;
  assign crystal_amp_en_o             = xamp_en_reg;
  assign crystal_amp_sel_o            = xamp_sel_reg;
  assign rc_osc_en_o                  = rc_en_reg;
  assign effective_clock_out_enable_o = eff_oe_reg;
endmodule
`default_nettype wire

// *** oscsel_asserts.sv ***
// Concurrent checks on the ports of the oscillator source selection top
`timescale 1ns/1ps
`default_nettype none
module oscsel_asserts
  import oscsel_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // Configuration
  input  wire logic [1:0] source_option_field_i,
  input  wire logic [1:0] crystal_range_field_i,
  input  wire logic       external_clock_enable_i,
  input  wire logic       clock_out_pin_enable_i,
  input  wire logic       osc_on_in_stop_i,
  input  wire logic       stop_osc_enable_signal_i,
  // Outputs
  input  wire logic       osc_in_pin_owned_o,
  input  wire logic       osc_out_pin_oe_n_o,
  input  wire logic       osc_out_pin_owned_o,
  input  wire logic       crystal_amp_en_o,
  input  wire logic [2:0] crystal_amp_sel_o,
  input  wire logic       rc_osc_en_o,
  input  wire logic       internal_osc_run_o,
  input  wire logic       external_clock_engaged_o,
  input  wire logic       effective_clock_out_enable_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  property p_ext_oe;
    (source_option_field_i == SRC_EXT_CLK)[*2]
      |-> osc_out_pin_oe_n_o && !effective_clock_out_enable_o;
  endproperty
  a_ext_oe: assert property (p_ext_oe) else $error("clock out not forced off");
  property p_rc_out;
    (source_option_field_i == SRC_RC && clock_out_pin_enable_i)[*2] |-> !osc_out_pin_oe_n_o;
  endproperty
  a_rc_out: assert property (p_rc_out) else $error("rc clock out missing");
  property p_int_gpio;
    (source_option_field_i == SRC_INTERNAL && !clock_out_pin_enable_i)[*2]
      |-> osc_out_pin_oe_n_o && !osc_out_pin_owned_o;
  endproperty
  a_int_gpio: assert property (p_int_gpio) else $error("second pin not released");
  property p_xtal_pin;
    (source_option_field_i == SRC_CRYSTAL)[*2] |-> osc_out_pin_owned_o;
  endproperty
  a_xtal_pin: assert property (p_xtal_pin) else $error("crystal pin not owned");
  property p_in_pin;
    (source_option_field_i == SRC_INTERNAL)[*2] |-> !osc_in_pin_owned_o;
  endproperty
  a_in_pin: assert property (p_in_pin) else $error("first pin not released");
  property p_amp_sel;
    (source_option_field_i == SRC_CRYSTAL)[*2] ##0 $stable(crystal_range_field_i)
      |-> crystal_amp_sel_o == ((crystal_range_field_i == XRANGE_RSVD) ? 3'b000 :
                                (3'b001 << crystal_range_field_i));
  endproperty
  a_amp_sel: assert property (p_amp_sel) else $error("amplifier select wrong");
  property p_stop;
    (!stop_osc_enable_signal_i && !osc_on_in_stop_i)[*2] |-> !crystal_amp_en_o && !rc_osc_en_o;
  endproperty
  a_stop: assert property (p_stop) else $error("oscillator runs in stop");
  property p_engage;
    $rose(external_clock_engaged_o) |-> internal_osc_run_o ##1 !internal_osc_run_o;
  endproperty
  a_engage: assert property (p_engage) else $error("engage order wrong");
  property p_edges;
    $rose(external_clock_engaged_o) |-> $past(external_clock_enable_i)
      && $past(external_clock_enable_i, 2) && $past(external_clock_enable_i, 3);
  endproperty
  a_edges: assert property (p_edges) else $error("engaged too early");
  property p_back;
    $fell(external_clock_engaged_o) |-> internal_osc_run_o && !external_clock_enable_i;
  endproperty
  a_back: assert property (p_back) else $error("released before restart");
endmodule

bind oscsel_top oscsel_asserts u_chk (
  .clk_sys_i, .arst_n_i, .source_option_field_i, .crystal_range_field_i,
  .external_clock_enable_i, .clock_out_pin_enable_i, .osc_on_in_stop_i,
  .stop_osc_enable_signal_i, .osc_in_pin_owned_o, .osc_out_pin_oe_n_o, .osc_out_pin_owned_o,
  .crystal_amp_en_o, .crystal_amp_sel_o, .rc_osc_en_o, .internal_osc_run_o,
  .external_clock_engaged_o, .effective_clock_out_enable_o
);
`default_nettype wire

// *** oscsel_sys_model.sv ***
// Model of the system unit dividing the half-rate clock to the bus clock
`timescale 1ns/1ps
`default_nettype none
module oscsel_sys_model (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // From the oscillator and the bench
  input  wire logic half_rate_clock_i,
  input  wire logic stop_req_i,
  // To the oscillator and bus
  output logic      stop_osc_enable_signal_o,
  output logic      bus_clock_o
);
  logic half_reg, half_next, bus_reg, bus_next;
  always_comb begin
    half_next = half_rate_clock_i;
    bus_next  = bus_reg ^ (half_rate_clock_i & ~half_reg);
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_reg <= 1'b0;
      bus_reg  <= 1'b0;
    end else begin
      half_reg <= half_next;
      bus_reg  <= bus_next;
    end
  end
  assign bus_clock_o              = bus_reg;
  assign stop_osc_enable_signal_o = ~stop_req_i;
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the oscillator clock source selection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t value mismatch", $time); end end
module tb;
  import oscsel_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       arst_n_i  = 1'b0;
  logic [1:0] opt       = SRC_INTERNAL;
  logic [1:0] frq       = FREQ_4M0;
  logic [1:0] rng       = XRANGE_HIGH;
  logic [7:0] trim      = 8'h00;
  logic       een = 0, coe = 0, keep = 0, stp = 0, wmode = 0;
  logic       pin = 0, xt = 0, rc = 0, eng_d = 0;
  logic       in_own, out_pin, oe_n, out_own, amp_en, rc_en;
  logic       full, half, irun, eng, effoe, sten, busclk;
  logic [2:0] amp_sel;
  int         error_cnt = 0, n_checks = 0, cyc = 0, cnt = 0, t, h, b;
  int         seed      = 32'h9664;
  int         hv[4]     = '{HALF_4M0, HALF_8M0, HALF_12M8, HALF_25M6};
  int         tt[3];
  logic [7:0] tv[3]     = '{8'h80, 8'h00, 8'h7F};
  logic       exp_q[$];

  oscsel_top DUT (
    .clk_sys_i, .arst_n_i, .source_option_field_i(opt), .internal_freq_field_i(frq),
    .crystal_range_field_i(rng), .external_clock_enable_i(een),
    .clock_out_pin_enable_i(coe), .internal_trim_value_i(trim), .osc_on_in_stop_i(keep),
    .stop_osc_enable_signal_i(sten), .wait_mode_i(wmode), .osc_in_pin_i(pin),
    .crystal_osc_clock_i(xt), .rc_osc_clock_i(rc), .osc_in_pin_owned_o(in_own),
    .osc_out_pin_o(out_pin), .osc_out_pin_oe_n_o(oe_n), .osc_out_pin_owned_o(out_own),
    .crystal_amp_en_o(amp_en), .crystal_amp_sel_o(amp_sel), .rc_osc_en_o(rc_en),
    .full_rate_clock_o(full), .half_rate_clock_o(half), .internal_osc_run_o(irun),
    .external_clock_engaged_o(eng), .effective_clock_out_enable_o(effoe)
  );
  oscsel_sys_model sysu (
    .clk_sys_i, .arst_n_i, .half_rate_clock_i(half), .stop_req_i(stp),
    .stop_osc_enable_signal_o(sten), .bus_clock_o(busclk)
  );

  initial forever #2 clk_sys_i = ~clk_sys_i;

  // External sources and random wait mode
  always @(posedge clk_sys_i) begin
    cnt <= cnt + 1;
    if (cnt % 7 == 0) pin <= ~pin;
    if (cnt % 9 == 0) rc <= ~rc;
    if (cnt % 5 == 0) xt <= ~xt;
    wmode <= 1'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end

  // Switch monitor
  always @(posedge clk_sys_i) begin
    if (arst_n_i && eng !== eng_d) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("[FAIL] %0t unexpected switch", $time);
      end else `CHK(eng, exp_q.pop_front())
    end
    eng_d <= eng;
  end

  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic measure();
    int  n, k;
    logic pf, ph, pb;
    {n, t, h, b} = '0;
    {pf, ph, pb} = {full, half, busclk};
    for (k = 0; k < 6000 && n < 17; k++) begin
      @(posedge clk_sys_i);
      #1;
      if (n > 0) begin
        t++;
        h += int'(half && !ph);
        b += int'(busclk && !pb);
      end
      n += int'(full && !pf);
      {pf, ph, pb} = {full, half, busclk};
    end
    @(posedge clk_sys_i);
  endtask

  task automatic wait_eng(input logic v);
    for (int k = 0; k < 400 && eng !== v; k++) @(posedge clk_sys_i);
    #1;
    `CHK(eng, v)
  endtask

  task automatic engage(input logic [1:0] s, input int per);
    @(posedge clk_sys_i);
    opt <= s;
    coe <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK(in_own, 1'b1)
    repeat (40) @(posedge clk_sys_i);
    exp_q.push_back(1'b1);
    een <= 1'b1;
    wait_eng(1'b1);
    measure();
    #1;
    `CHK(out_pin, (s == SRC_RC))
    `CHK(t inside {[16*per-8:16*per+8]}, 1'b1)
    `CHK(h inside {[7:9]}, 1'b1)
    @(posedge clk_sys_i);
    {opt, een, coe} <= '0;
    exp_q.push_back(1'b0);
    wait_eng(1'b0);
    `CHK(irun, 1'b1)
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_i);
    `CHK({eng, irun, oe_n}, 3'b011)
    arst_n_i <= 1'b1;
    foreach (hv[i]) begin
      frq <= 2'(i);
      repeat (200) @(posedge clk_sys_i);
      measure();
      `CHK(t inside {[32*hv[i]-16:32*hv[i]+48]}, 1'b1)
      `CHK(h inside {[7:9]}, 1'b1)
      `CHK(b inside {[3:5]}, 1'b1)
    end
    frq <= FREQ_4M0;
    foreach (tv[i]) begin
      trim <= tv[i];
      repeat (200) @(posedge clk_sys_i);
      measure();
      tt[i] = t;
    end
    `CHK(tt[0] < tt[1] && tt[1] < tt[2], 1'b1)
    repeat (100) begin
      {opt, rng, coe, stp, keep} <= 7'($random(seed));
      repeat (3) @(posedge clk_sys_i);
    end
    {opt, coe, stp, keep, rng} <= '0;
    repeat (20) @(posedge clk_sys_i);
    opt <= SRC_RC;
    repeat (20) @(posedge clk_sys_i);
    een <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    een <= 1'b0;
    repeat (100) @(posedge clk_sys_i);
    #1;
    `CHK(eng, 1'b0)
    engage(SRC_EXT_CLK, 14);
    engage(SRC_RC, 18);
    // Crystal option held first while the range is stepped
    @(posedge clk_sys_i);
    opt <= SRC_CRYSTAL;
    for (int r = 0; r < 4; r++) begin
      rng <= 2'(r);
      repeat (5) @(posedge clk_sys_i);
    end
    rng <= XRANGE_HIGH;
    engage(SRC_CRYSTAL, 10);
    repeat (20) @(posedge clk_sys_i);
    final_report();
  end
endmodule
`default_nettype wire
